// *** src/chb_status_top.v ***
// Operation
// - special type: 0 none,1 suspend,2 resume
// - count bits 15:0, length bits 31:16
// - multi-block count 1..65535, zero unbounded
// - SDIO byte count zero means 512
// - SDIO block count zero means unbounded
// - SDIO byte mode ignores block length
// - one block length, two register views
// - response words read out in sequence
// - command done cleared by command write
// - receive ready and transmit taken flags
// - block ended on write CRC status, in DMA mode only once both TX counters are zero
// - transfer active until CRC16 completes
// - not busy cleared at write response end
// - DMA counter end flags
// - buffer flags when both counters zero
// - response index and direction errors
// - response CRC7 and end bit errors
// - response timeout by latency select
// - data CRC and timeout cleared reading
// - overrun/underrun cleared by data command
// - latency limit 5 or 64 cycles
// - data timeout equals cycles times scale
`timescale 1ns/100ps
`include "chb_map.vh"
module chb_status_top #(
	parameter RSP_DEPTH = 4
)(
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// card pins
	input  wire        card_clk_i,
	input  wire        card_dat0_i,
	// card engine events
	input  wire        eng_cmd_done,
	input  wire        eng_rsp_start,
	input  wire        eng_rsp_valid,
	input  wire [31:0] eng_rsp_data,
	input  wire        eng_rsp_last,
	input  wire [5:0]  eng_rsp_index,
	input  wire        eng_rsp_dir,
	input  wire        eng_rsp_crc_ok,
	input  wire        eng_rsp_end_ok,
	input  wire        eng_rx_valid,
	input  wire [31:0] eng_rx_word,
	input  wire        eng_tx_take,
	input  wire        eng_crc_status,
	input  wire        eng_crc_bad,
	input  wire        eng_data_done,
	input  wire        dma_rx_beat,
	input  wire        dma_tx_beat,
	// to card engine
	output reg         cmd_start_o,
	output reg  [31:0] cmd_word_o,
	output reg  [16:0] blk_count_o,
	output reg         blk_infinite_o,
	output reg  [15:0] blk_len_o,
	output reg         sdio_suspend_o,
	output reg         sdio_resume_o,
	output reg  [31:0] tx_word_o
);

	reg  [1:0]  clk_sync_ff;
	reg  [1:0]  dat_sync_ff;
	reg         clk_prev_ff;
	reg         dat_prev_ff;
	reg  [15:0] mode_ff;
	reg  [15:0] block_length_ff;
	reg  [15:0] transfer_count_ff;
	reg  [6:0]  dtor_ff;
	reg  [31:0] rx_ff;
	reg  [31:0] rsp_mem [0:RSP_DEPTH-1];
	reg  [1:0]  rsp_wp_ff;
	reg  [1:0]  rsp_rp_ff;
	reg         cdone_ff;
	reg         rx_word_ready_ff;
	reg         txtk_ff;
	reg         block_ended_ff;
	reg         dta_ff;
	reg         nbsy_ff;
	reg  [3:0]  rsperr_ff;
	reg         resp_timeout_error_ff;
	reg         data_crc_error_ff;
	reg         data_timeout_error_ff;
	reg         rx_overrun_error_ff;
	reg         tx_underrun_error_ff;
	reg         rwait_ff;
	reg  [6:0]  lat_ff;
	reg  [24:0] dto_ff;
	reg  [15:0] dcur_ff [0:1];
	reg  [15:0] dnxt_ff [0:1];
	reg  [1:0]  dend_ff;
	reg  [31:0] nxt_rdata;
	reg  [20:0] nxt_mul;
	reg  [16:0] nxt_count;
	reg         nxt_inf;

	// bus decode
	wire        req     = wb_cyc_i & wb_stb_i;
	wire        acc     = req & ~wb_ack_o;
	wire        wr      = acc & wb_we_i;
	wire        rd      = acc & ~wb_we_i;
	wire [7:0]  adr     = {wb_adr_i[7:2], 2'h0};
	wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] wdat    = wb_dat_i & wmask;
	wire        cmd_wr  = wr & (adr == `CHB_CMDR) & cdone_ff;
	wire        sr_rd   = rd & (adr == `CHB_SR);
	wire        rdr_rd  = rd & (adr == `CHB_RDR);
	wire        tdr_wr  = wr & (adr == `CHB_TDR);
	wire        rsp_rd  = rd & (adr >= `CHB_RSPR) & (adr <= `CHB_RSPR_LAST);
	wire        link_up = clk_sync_ff[1] & ~clk_prev_ff;
	wire        dat_up  = dat_sync_ff[1] & ~dat_prev_ff;

	// fields of the last command and of the command being written
	wire [2:0]  transfer_type   = cmd_word_o[`CHB_CMD_TRT_LO+2:`CHB_CMD_TRT_LO];
	wire        trdir   = cmd_word_o[`CHB_CMD_TRDIR];
	wire [1:0]  new_trc = wb_dat_i[`CHB_CMD_TRC_LO+1:`CHB_CMD_TRC_LO];
	wire [1:0]  new_rsp = wb_dat_i[`CHB_CMD_RSPT_LO+1:`CHB_CMD_RSPT_LO];
	wire [1:0]  new_iosp = wb_dat_i[`CHB_CMD_IOSP_LO+1:`CHB_CMD_IOSP_LO];
	wire [6:0]  lat_lim = cmd_word_o[`CHB_CMD_LAT] ? `CHB_LAT_LONG : `CHB_LAT_SHORT;
	wire [24:0] dto_lim = {21'h0, dtor_ff[3:0]} * {4'h0, nxt_mul};
	wire        dat_evt = eng_rx_valid | eng_tx_take | eng_crc_status;
	wire        rsp_chk = eng_rsp_valid & eng_rsp_last;
	wire [1:0]  dbeat   = {dma_tx_beat, dma_rx_beat};
	wire [1:0]  dzero;
	wire [31:0] status;

	assign status = {tx_underrun_error_ff, rx_overrun_error_ff, 7'h0, data_timeout_error_ff, data_crc_error_ff, resp_timeout_error_ff,
		rsperr_ff, dzero[1], dzero[0], 6'h0, dend_ff, nbsy_ff, dta_ff,
		block_ended_ff, txtk_ff, rx_word_ready_ff, cdone_ff};

	// pin synchronisers
	always @(posedge clk_sys) begin
		if (rst) begin
			clk_sync_ff <= 2'h0;
			dat_sync_ff <= 2'h3;
			clk_prev_ff <= 1'b0;
			dat_prev_ff <= 1'b1;
		end else begin
			clk_sync_ff <= {clk_sync_ff[0], card_clk_i};
			dat_sync_ff <= {dat_sync_ff[0], card_dat0_i};
			clk_prev_ff <= clk_sync_ff[1];
			dat_prev_ff <= dat_sync_ff[1];
		end
	end

	// timeout scale
	always @* begin
		case (dtor_ff[6:4])
			3'h0: nxt_mul = `CHB_MUL0;
			3'h1: nxt_mul = `CHB_MUL1;
			3'h2: nxt_mul = `CHB_MUL2;
			3'h3: nxt_mul = `CHB_MUL3;
			3'h4: nxt_mul = `CHB_MUL4;
			3'h5: nxt_mul = `CHB_MUL5;
			3'h6: nxt_mul = `CHB_MUL6;
			default: nxt_mul = `CHB_MUL7;
		endcase
	end

	// count decode per transfer type
	always @* begin
		nxt_inf = 1'b0;
		case (transfer_type)
			`CHB_TRT_MULTI: begin
				nxt_count = {1'b0, transfer_count_ff};
				nxt_inf   = (transfer_count_ff == 16'h0000);
			end
			`CHB_TRT_SBYTE: begin
				nxt_count = (transfer_count_ff[8:0] == 9'h000) ? `CHB_SDIO_BYTES
					: {8'h00, transfer_count_ff[8:0]};
			end
			`CHB_TRT_SBLK: begin
				nxt_count = {8'h00, transfer_count_ff[8:0]};
				nxt_inf   = (transfer_count_ff[8:0] == 9'h000);
			end
			default: nxt_count = 17'h00001;
		endcase
	end

	// read mux
	always @* begin
		case (adr)
			`CHB_MR:   nxt_rdata = {block_length_ff, mode_ff};
			`CHB_DTOR: nxt_rdata = {25'h0, dtor_ff};
			`CHB_BLKR: nxt_rdata = {block_length_ff, transfer_count_ff};
			`CHB_RDR:  nxt_rdata = rx_ff;
			`CHB_SR:   nxt_rdata = status;
			`CHB_RCR:  nxt_rdata = {16'h0, dcur_ff[0]};
			`CHB_RNCR: nxt_rdata = {16'h0, dnxt_ff[0]};
			`CHB_TCR:  nxt_rdata = {16'h0, dcur_ff[1]};
			`CHB_TNCR: nxt_rdata = {16'h0, dnxt_ff[1]};
			default:   nxt_rdata = rsp_rd ? rsp_mem[rsp_rp_ff] : 32'h0;
		endcase
	end

	// response store
	always @(posedge clk_sys) begin
		if (eng_rsp_valid)
			rsp_mem[rsp_wp_ff] <= eng_rsp_data;
	end

	// bus, registers, command side
	always @(posedge clk_sys) begin
		if (rst) begin
			wb_ack_o       <= 1'b0;
			wb_dat_o       <= 32'h0;
			mode_ff        <= 16'h0;
			block_length_ff      <= 16'h0;
			transfer_count_ff        <= 16'h0;
			dtor_ff        <= 7'h0;
			cmd_start_o    <= 1'b0;
			cmd_word_o     <= 32'h0;
			sdio_suspend_o <= 1'b0;
			sdio_resume_o  <= 1'b0;
			blk_count_o    <= 17'h0;
			blk_infinite_o <= 1'b0;
			blk_len_o      <= 16'h0;
			tx_word_o      <= 32'h0;
			rsp_wp_ff      <= 2'h0;
			rsp_rp_ff      <= 2'h0;
		end else begin
			wb_ack_o    <= acc;
			cmd_start_o <= cmd_wr;
			if (rd)
				wb_dat_o <= nxt_rdata;
			if (wr & (adr == `CHB_MR)) begin
				mode_ff   <= (mode_ff & ~wmask[15:0]) | wdat[15:0];
				block_length_ff <= (block_length_ff & ~wmask[31:16]) | wdat[31:16];
			end
			if (wr & (adr == `CHB_BLKR)) begin
				transfer_count_ff   <= (transfer_count_ff & ~wmask[15:0]) | wdat[15:0];
				block_length_ff <= (block_length_ff & ~wmask[31:16]) | wdat[31:16];
			end
			if (wr & (adr == `CHB_DTOR))
				dtor_ff <= (dtor_ff & ~wmask[6:0]) | wdat[6:0];
			if (cmd_wr) begin
				cmd_word_o     <= wb_dat_i;
				sdio_suspend_o <= (new_iosp == `CHB_IOSP_SUSP);
				sdio_resume_o  <= (new_iosp == `CHB_IOSP_RES);
			end
			if (tdr_wr)
				tx_word_o <= (tx_word_o & ~wmask) | wdat;
			blk_count_o    <= nxt_count;
			blk_infinite_o <= nxt_inf;
			blk_len_o      <= (transfer_type == `CHB_TRT_SBYTE) ? 16'h0 : block_length_ff;
			if (cmd_wr) begin
				rsp_wp_ff <= 2'h0;
				rsp_rp_ff <= 2'h0;
			end else begin
				if (eng_rsp_valid)
					rsp_wp_ff <= rsp_wp_ff + 2'h1;
				if (rsp_rd)
					rsp_rp_ff <= rsp_rp_ff + 2'h1;
			end
		end
	end

	// status flags; a set wins over a clear
	always @(posedge clk_sys) begin
		if (rst) begin
			cdone_ff  <= 1'b1;
			rx_word_ready_ff  <= 1'b0;
			txtk_ff   <= 1'b1;
			block_ended_ff   <= 1'b0;
			dta_ff    <= 1'b0;
			nbsy_ff   <= 1'b1;
			rsperr_ff <= 4'h0;
			resp_timeout_error_ff   <= 1'b0;
			data_crc_error_ff  <= 1'b0;
			data_timeout_error_ff   <= 1'b0;
			rx_overrun_error_ff   <= 1'b0;
			tx_underrun_error_ff   <= 1'b0;
			rx_ff     <= 32'h0;
		end else begin
			cdone_ff <= eng_cmd_done | (cdone_ff & ~cmd_wr);
			if (eng_rx_valid)
				rx_ff <= eng_rx_word;
			rx_word_ready_ff <= eng_rx_valid | (rx_word_ready_ff & ~rdr_rd);
			txtk_ff  <= eng_tx_take | (txtk_ff & ~tdr_wr);
			block_ended_ff  <= (eng_crc_status & ~trdir & (~mode_ff[`CHB_MR_DMAM] | dzero[1]))
				| (block_ended_ff & ~sr_rd);
			dta_ff   <= (cmd_wr & (new_trc == `CHB_TRC_START))
				| (dta_ff & ~eng_data_done);
			nbsy_ff  <= dat_up | (nbsy_ff & ~(eng_rsp_valid & eng_rsp_last & ~trdir));
			rsperr_ff[0] <= (rsp_chk & (eng_rsp_index != cmd_word_o[5:0]))
				| (rsperr_ff[0] & ~cmd_wr);
			rsperr_ff[1] <= (rsp_chk & ~eng_rsp_dir) | (rsperr_ff[1] & ~cmd_wr);
			rsperr_ff[2] <= (rsp_chk & ~eng_rsp_crc_ok) | (rsperr_ff[2] & ~cmd_wr);
			rsperr_ff[3] <= (rsp_chk & ~eng_rsp_end_ok) | (rsperr_ff[3] & ~cmd_wr);
			resp_timeout_error_ff  <= (rwait_ff & link_up & (lat_ff == lat_lim - 7'h01))
				| (resp_timeout_error_ff & ~cmd_wr);
			data_crc_error_ff <= eng_crc_bad | (data_crc_error_ff & ~sr_rd);
			data_timeout_error_ff  <= (dta_ff & ~dat_evt & (dto_ff == dto_lim))
				| (data_timeout_error_ff & ~sr_rd);
			rx_overrun_error_ff  <= (eng_rx_valid & rx_word_ready_ff & ~rdr_rd)
				| (rx_overrun_error_ff & ~(cmd_wr & (new_trc == `CHB_TRC_START)));
			tx_underrun_error_ff  <= (eng_tx_take & txtk_ff)
				| (tx_underrun_error_ff & ~(cmd_wr & (new_trc == `CHB_TRC_START)));
		end
	end

	// response wait and data timeout counters
	always @(posedge clk_sys) begin
		if (rst) begin
			rwait_ff <= 1'b0;
			lat_ff   <= 7'h0;
			dto_ff   <= 25'h0;
		end else begin
			if (cmd_wr) begin
				rwait_ff <= (new_rsp != 2'h0);
				lat_ff   <= 7'h0;
			end else if (eng_rsp_start) begin
				rwait_ff <= 1'b0;
			end else if (rwait_ff & link_up) begin
				lat_ff <= lat_ff + 7'h01;
				if (lat_ff == lat_lim - 7'h01)
					rwait_ff <= 1'b0;
			end
			if (~dta_ff | dat_evt)
				dto_ff <= 25'h0;
			else if (dto_ff != dto_lim)
				dto_ff <= dto_ff + 25'h1;
		end
	end

	// dma counters, one channel per direction
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : dch
			wire cur_wr = wr & (adr == (g ? `CHB_TCR : `CHB_RCR));
			wire nxt_wr = wr & (adr == (g ? `CHB_TNCR : `CHB_RNCR));
			wire hit0   = dbeat[g] & (dcur_ff[g] == 16'h0001);
			assign dzero[g] = (dcur_ff[g] == 16'h0) & (dnxt_ff[g] == 16'h0);
			always @(posedge clk_sys) begin
				if (rst) begin
					dcur_ff[g] <= 16'h0;
					dnxt_ff[g] <= 16'h0;
					dend_ff[g] <= 1'b0;
				end else begin
					dend_ff[g] <= hit0 | (dend_ff[g] & ~(cur_wr | nxt_wr));
					if (cur_wr)
						dcur_ff[g] <= (dcur_ff[g] & ~wmask[15:0]) | wdat[15:0];
					else if (hit0) begin
						dcur_ff[g] <= dnxt_ff[g];
					end else if (dbeat[g] & (dcur_ff[g] != 16'h0))
						dcur_ff[g] <= dcur_ff[g] - 16'h0001;
					if (nxt_wr)
						dnxt_ff[g] <= (dnxt_ff[g] & ~wmask[15:0]) | wdat[15:0];
					else if (hit0 & ~cur_wr)
						dnxt_ff[g] <= 16'h0;
				end
			end
		end
	endgenerate

endmodule

// *** src/chb_map.vh ***
`ifndef CHB_MAP_VH
`define CHB_MAP_VH

// register byte offsets
`define CHB_MR        8'h04
`define CHB_DTOR      8'h08
`define CHB_CMDR      8'h0C
`define CHB_BLKR      8'h18
`define CHB_RSPR      8'h20
`define CHB_RSPR_LAST 8'h2C
`define CHB_RDR       8'h30
`define CHB_TDR       8'h34
`define CHB_SR        8'h40
`define CHB_RCR       8'h50
`define CHB_RNCR      8'h54
`define CHB_TCR       8'h58
`define CHB_TNCR      8'h5C

// mode register fields
`define CHB_MR_FBYTE  13
`define CHB_MR_DMAM   15

// command register fields
`define CHB_CMD_RSPT_LO 6
`define CHB_CMD_LAT     12
`define CHB_CMD_TRC_LO  16
`define CHB_CMD_TRDIR   18
`define CHB_CMD_TRT_LO  19
`define CHB_CMD_IOSP_LO 24

// field codes
`define CHB_TRC_START  2'h1
`define CHB_TRT_SINGLE 3'h0
`define CHB_TRT_MULTI  3'h1
`define CHB_TRT_SBYTE  3'h4
`define CHB_TRT_SBLK   3'h5
`define CHB_IOSP_SUSP  2'h1
`define CHB_IOSP_RES   2'h2
`define CHB_SDIO_BYTES 17'h00200

// status bit positions
`define CHB_SR_CDONE 0
`define CHB_SR_RX_WORD_READY 1
`define CHB_SR_TXTK  2
`define CHB_SR_BLOCK_ENDED  3
`define CHB_SR_DTA   4
`define CHB_SR_NBSY  5
`define CHB_SR_RX_COUNT_DONE 6
`define CHB_SR_RXBF  14
`define CHB_SR_RESP_INDEX_ERROR 16
`define CHB_SR_DATA_TIMEOUT_ERROR  22
`define CHB_SR_RX_OVERRUN_ERROR  30
`define CHB_SR_TX_UNDERRUN_ERROR  31

// timing in link clock cycles
`define CHB_LAT_SHORT 7'h05
`define CHB_LAT_LONG  7'h40

// data timeout multipliers
`define CHB_MUL0 21'h000001
`define CHB_MUL1 21'h000010
`define CHB_MUL2 21'h000080
`define CHB_MUL3 21'h000100
`define CHB_MUL4 21'h000400
`define CHB_MUL5 21'h001000
`define CHB_MUL6 21'h010000
`define CHB_MUL7 21'h100000

`endif

// *** tb/chb_status_top_assertions.sv ***
`timescale 1ns/100ps
`include "chb_map.vh"
module chb_status_chk (
	// clock and reset
	input wire        clk_sys,
	input wire        rst,
	// bus
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire        wb_ack_o,
	// engine side
	input wire        cmd_start_o,
	input wire [31:0] cmd_word_o,
	input wire [16:0] blk_count_o,
	input wire        blk_infinite_o,
	input wire [15:0] blk_len_o,
	input wire        sdio_suspend_o,
	input wire        sdio_resume_o,
	input wire [31:0] tx_word_o
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire       req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire       cmdw = req && wb_we_i && wb_adr_i[7:2] == 6'h03;
	wire [2:0] trt  = cmd_word_o[21:19];
	wire [1:0] spc  = cmd_word_o[25:24];
	a_ack_next: assert property (req |=> wb_ack_o)
		else $error("ack late");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_start_cause: assert property (cmd_start_o |-> $past(cmdw))
		else $error("start without write");
	a_start_once: assert property (cmd_start_o |=> !cmd_start_o)
		else $error("start too long");
	a_special_dec: assert property ($stable(cmd_word_o) |->
		sdio_suspend_o == (spc == `CHB_IOSP_SUSP) && sdio_resume_o == (spc == `CHB_IOSP_RES))
		else $error("special decode");
	a_byte_len: assert property ($stable(cmd_word_o) && trt == `CHB_TRT_SBYTE |->
		blk_len_o == 16'h0000) else $error("length in byte mode");
	a_byte_count: assert property ($stable(cmd_word_o) && trt == `CHB_TRT_SBYTE |->
		blk_count_o != 17'h0 && blk_count_o <= `CHB_SDIO_BYTES && !blk_infinite_o)
		else $error("byte count range");
	a_tx_cause: assert property ($changed(tx_word_o) |->
		$past(req && wb_we_i && wb_adr_i[7:2] == 6'h0D)) else $error("tx word change");
	c_cmd: cover property (cmdw);
	c_susp: cover property (sdio_suspend_o);
	c_inf: cover property (blk_infinite_o);
endmodule
bind chb_status_top chb_status_chk u_chk (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_ack_o, .cmd_start_o, .cmd_word_o, .blk_count_o, .blk_infinite_o,
	.blk_len_o, .sdio_suspend_o, .sdio_resume_o, .tx_word_o);

// *** tb/chb_card_model.sv ***
`timescale 1ns/100ps
module chb_card_model (
	// frame control
	input wire  run,
	// card holds data line zero low while busy
	input wire  busy,
	// card pins
	output reg  card_clk_i,
	output wire card_dat0_i
);
	// link clock only within frames, phase apart from system clock
	initial begin
		card_clk_i = 1'b0;
		#130;
		forever #400 card_clk_i = run ? ~card_clk_i : 1'b0;
	end
	// busy pulls data line zero low, release lets it go high
	assign card_dat0_i = ~busy;
endmodule

// *** tb/chb_status_top_bench.sv ***
`timescale 1ns/100ps
`include "chb_map.vh"
module chb_status_top_bench;
	reg         clk_sys = 1'b0;
	reg         rst = 1'b1;
	reg         cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, busy = 1'b0;
	reg  [7:0]  adr = 8'h00;
	reg  [31:0] wdat = 32'h0, edat = 32'h0, q;
	reg  [13:0] ev = 14'h0070;
	reg  [5:0]  ridx = 6'h05;
	reg  [72:0] rows [0:7];
	reg  [97:0] crow [0:4];
	wire [31:0] dato, cword, txw;
	wire        ack, cstart, cinf, susp, resm, cclk, dat0;
	wire [16:0] transfer_count;
	wire [15:0] blen;
	integer     failures = 0, n_compared = 0, cyc_n = 0, n_start = 0, k;
	always #50 clk_sys = ~clk_sys;
	chb_status_top u_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dato),
		.wb_ack_o(ack), .card_clk_i(cclk), .card_dat0_i(dat0), .eng_cmd_done(ev[0]),
		.eng_rsp_start(ev[1]), .eng_rsp_valid(ev[2]), .eng_rsp_data(edat),
		.eng_rsp_last(ev[3]), .eng_rsp_index(ridx), .eng_rsp_dir(ev[4]),
		.eng_rsp_crc_ok(ev[5]), .eng_rsp_end_ok(ev[6]), .eng_rx_valid(ev[7]),
		.eng_rx_word(edat), .eng_tx_take(ev[8]), .eng_crc_status(ev[9]),
		.eng_crc_bad(ev[10]), .eng_data_done(ev[11]), .dma_rx_beat(ev[12]),
		.dma_tx_beat(ev[13]), .cmd_start_o(cstart), .cmd_word_o(cword),
		.blk_count_o(transfer_count), .blk_infinite_o(cinf), .blk_len_o(blen),
		.sdio_suspend_o(susp), .sdio_resume_o(resm), .tx_word_o(txw));
	chb_card_model u_card (.run(run), .busy(busy), .card_clk_i(cclk), .card_dat0_i(dat0));
	task automatic bus(input [7:0] a, input w, input [31:0] d);
		begin
			@(posedge clk_sys);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			wdat <= d;
			@(posedge clk_sys);
			while (ack !== 1'b1) begin
				@(posedge clk_sys);
			end
			q = dato;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask
	task automatic chk(input string nm, input [31:0] s, input [31:0] e);
		begin
			n_compared = n_compared + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("BAD %s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task automatic pe(input [13:0] m);
		begin
			@(posedge clk_sys);
			ev <= ev | m;
			@(posedge clk_sys);
			ev <= ev & ~m;
		end
	endtask
	task stop_test;
		begin
			$display("compared %0d failures %0d", n_compared, failures);
			if (failures == 0 && n_compared > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	always @(posedge clk_sys) begin
		cyc_n = cyc_n + 1;
		if (cstart === 1'b1)
			n_start = n_start + 1;
		if (cyc_n == 12000) begin
			failures = failures + 1;
			stop_test;
		end
	end
	initial begin
		// block lengths keep bits 16,17 clear
		rows[0] = {`CHB_BLKR, 1'b1, 32'h00100003, 32'h0};
		rows[1] = {`CHB_BLKR, 1'b0, 32'h0, 32'h00100003};
		rows[2] = {`CHB_MR, 1'b1, 32'h00200000, 32'h0};
		rows[3] = {`CHB_BLKR, 1'b0, 32'h0, 32'h00200003};
		rows[4] = {8'h7C, 1'b0, 32'h0, 32'h0};
		rows[5] = {`CHB_RCR, 1'b1, 32'h1, 32'h0};
		rows[6] = {`CHB_RNCR, 1'b1, 32'h0, 32'h0};
		rows[7] = {`CHB_SR, 1'b0, 32'h0, 32'h00008025};
		// counts below 0x200 in sdio rows
		crow[0] = {32'h00400000, 32'h00210005, 17'h00200, 1'b0, 16'h0000};
		crow[1] = {32'h00400007, 32'h01290005, 17'h00007, 1'b0, 16'h0040};
		crow[2] = {32'h00400000, 32'h02290005, 17'h00000, 1'b1, 16'h0040};
		crow[3] = {32'h0040FFFF, 32'h00090005, 17'h0FFFF, 1'b0, 16'h0040};
		crow[4] = {32'h00400000, 32'h03090005, 17'h00000, 1'b1, 16'h0040};
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("sr_reset", q, 32'h0000C025);
		for (k = 0; k < 8; k = k + 1) begin
			bus(rows[k][72:65], rows[k][64], rows[k][63:32]);
			if (!rows[k][64])
				chk("row", q, rows[k][31:0]);
		end
		pe(14'h1000);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("dma_end", q, 32'h0000C065);
		bus(`CHB_TDR, 1'b1, 32'hA5A50F0F);
		chk("tx_word", txw, 32'hA5A50F0F);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("tx_wait", q[2], 32'h0);
		edat <= 32'h12345678;
		pe(14'h0180);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("rx_tx_set", q[2:1], 32'h3);
		bus(`CHB_RDR, 1'b0, 32'h0);
		chk("rx_data", q, 32'h12345678);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("rx_clear", q[1], 32'h0);
		for (k = 0; k < 5; k = k + 1) begin
			bus(`CHB_BLKR, 1'b1, crow[k][97:66]);
			bus(`CHB_CMDR, 1'b1, crow[k][65:34]);
			bus(`CHB_CMDR, 1'b1, 32'h0000003F);
			bus(`CHB_SR, 1'b0, 32'h0);
			chk("cmd_busy", q[0], 32'h0);
			chk("active", q[4], 32'h1);
			chk("dto_set", q[22], 32'h1);
			chk("cmd_word", cword, crow[k][65:34]);
			chk("special", {susp, resm}, {crow[k][59:58] == 2'h1, crow[k][59:58] == 2'h2});
			chk("inf", cinf, crow[k][16]);
			if (!crow[k][16])
				chk("count", transfer_count, crow[k][33:17]);
			chk("len", blen, crow[k][15:0]);
			pe(14'h0001);
		end
		pe(14'h0800);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("active_end", q[4], 32'h0);
		bus(`CHB_CMDR, 1'b1, 32'h00000045);
		pe(14'h0001);
		run <= 1'b1;
		repeat (72) @(posedge clk_sys);
		run <= 1'b0;
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("rsp_to_short", q[20], 32'h1);
		bus(`CHB_CMDR, 1'b1, 32'h00001045);
		pe(14'h0001);
		run <= 1'b1;
		repeat (72) @(posedge clk_sys);
		run <= 1'b0;
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("rsp_to_long", q[20], 32'h0);
		edat <= 32'h11110001;
		pe(14'h0006);
		edat <= 32'h22220002;
		ridx <= 6'h09;
		@(posedge clk_sys);
		ev[5:4] <= 2'b00;
		pe(14'h000C);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("rsp_err", q[19:16], 32'h7);
		chk("nbsy_clr", q[5], 32'h0);
		bus(8'h20, 1'b0, 32'h0);
		chk("rsp_w0", q, 32'h11110001);
		bus(8'h24, 1'b0, 32'h0);
		chk("rsp_w1", q, 32'h22220002);
		busy <= 1'b1;
		repeat (4) @(posedge clk_sys);
		busy <= 1'b0;
		repeat (6) @(posedge clk_sys);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("nbsy_set", q[5], 32'h1);
		ev[5:4] <= 2'b11;
		bus(`CHB_CMDR, 1'b1, 32'h00000005);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("rsp_clr", q[20:16], 32'h0);
		pe(14'h0401);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("dcrc_set", q[21], 32'h1);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("dcrc_clr", q[21], 32'h0);
		pe(14'h0200);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("block_ended_set", q[3], 32'h1);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("block_ended_clr", q[3], 32'h0);
		bus(`CHB_MR, 1'b1, 32'h00408000);
		bus(`CHB_TCR, 1'b1, 32'h00000002);
		pe(14'h0200);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("block_ended_dma", q[3], 32'h0);
		chk("tx_buffers_empty_lo", q[15], 32'h0);
		pe(14'h0080);
		pe(14'h0180);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("ovr_unr_set", q[31:30], 32'h3);
		bus(`CHB_CMDR, 1'b1, 32'h00010005);
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("ovr_unr_clr", q[31:30], 32'h0);
		chk("starts", n_start, 32'h9);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		bus(`CHB_SR, 1'b0, 32'h0);
		chk("sr_rerst", q, 32'h0000C025);
		bus(`CHB_BLKR, 1'b0, 32'h0);
		chk("blkr_rerst", q, 32'h0);
		stop_test;
	end
endmodule
